/* core/wdf_pkg.sv */
// constants shared by the watchdog with feed sequence
package wdf_pkg;
  // register indices on the plain register port
  localparam logic [3:0] ADDR_CTRL = 4'h0; // control: select, run, timeout flag
  localparam logic [3:0] ADDR_AUTOLOAD = 4'h1; // autoload value
  localparam logic [3:0] ADDR_FEED1 = 4'h2; // first feed register
  localparam logic [3:0] ADDR_FEED2 = 4'h3; // second feed register
  localparam logic [3:0] ADDR_COUNT = 4'h4; // main counter, read only
  // feed keys
  localparam logic [7:0] FEED1_KEY = 8'hA5;
  localparam logic [7:0] FEED2_KEY = 8'h5A;
  // control field positions
  localparam int CTRL_SEL_HI = 7;
  localparam int CTRL_SEL_LO = 5;
  localparam int CTRL_RUN = 2;
  localparam int CTRL_TOF = 1;
  // reset values
  localparam logic [2:0] SEL_RST = 3'h7; // highest divide tap
  localparam logic RUN_RST = 1'b1; // watchdog runs after reset
  localparam logic [7:0] AUTOLOAD_RST = 8'h00; // minimum count
  // prescaler geometry: fastest tap is bit 5, giving 32 timer clocks
  localparam int PRE_W = 13;
  localparam int TAP_BASE = 5;
  localparam logic [12:0] PRE_ONES = 13'h1FFF;
  // default timer clock divider from the system clock
  localparam int DIV_N_DEF = 4;
  // feed sequence states, one-hot
  typedef enum logic [1:0] {
    FEED_IDLE = 2'b01,
    FEED_ARMED = 2'b10
  } wdf_feed_t;
endpackage : wdf_pkg

/* core/wdf_watchdog.sv */
// watchdog timer with prescaler, autoload and two-write feed sequence
// How it works
// - watchdog runs after every reset
// - underflow asserts full system reset
// - 13-bit prescaler on timer clock
// - counter ticks from selectable upper prescaler tap
// - fastest tap ticks every 32 clocks
// - tick at zero underflows and reloads
// - autoload accepts 00 through FF
// - every autoload clears the prescaler
// - timeout is N times P times W+1
// - counter never written directly by software
// - feed is A5 then 5A only
// - intervening access fails feed, resets
// - wrong second key resets immediately
// - select and run writes pend until valid feed
// - select codes give divisors 32 to 4096
// - external reset: run, zero autoload, top tap
// - underflow sets flag, keeps run, autoload, tap
// - control bits: select 7:5, run 2, flag 1
`timescale 1ns/1ns
`default_nettype none
module wdf_watchdog #(
  parameter int DIV_N = wdf_pkg::DIV_N_DEF // timer clock divider, 4 to 64
) (
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output logic o_wdt_reset,
  output logic o_timeout
);

  // timer clock divider state
  logic [5:0] div_r;
  logic [5:0] div_nxt;
  logic timer_source_clock_en; // one-cycle timer clock enable
  // watchdog core state
  logic [12:0] pre_r; // prescaler
  logic [12:0] pre_nxt;
  logic [7:0] cnt_r; // main down-counter
  logic [7:0] cnt_nxt;
  logic [7:0] wdl_r; // autoload_value_reg
  logic [7:0] wdl_nxt;
  logic [2:0] sel_r; // committed prescale select
  logic [2:0] sel_nxt;
  logic run_r; // committed run_enable_bit
  logic run_nxt;
  logic [2:0] pend_sel_r; // pending select, waits for feed
  logic [2:0] pend_sel_nxt;
  logic pend_run_r; // pending run, waits for feed
  logic pend_run_nxt;
  logic tof_r; // timeout_flag_bit
  logic tof_nxt;
  wdf_pkg::wdf_feed_t feed_r;
  wdf_pkg::wdf_feed_t feed_nxt;
  logic rst_r; // registered reset request
  logic rst_nxt;
  // read port state
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  // decoded events
  logic acc;
  logic wr_ctrl;
  logic wr_f1_key;
  logic feed_ok;
  logic bad_feed;
  logic [12:0] tap_mask;
  logic tick;
  logic uf;
  logic wdg_rst;

  // divider: timer clock enable every DIV_N system clocks
  always_comb begin
    if (div_r == 6'(DIV_N - 1)) begin
      div_nxt = 6'h0;
    end else begin
      div_nxt = div_r + 6'h1;
    end
  end
  assign timer_source_clock_en = (div_r == 6'(DIV_N - 1));

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      div_r <= 6'h0;
    end else begin
      div_r <= div_nxt;
    end
  end

  // access decode; any read or write counts as a register access
  assign acc = i_wr | i_rd;
  assign wr_ctrl = i_wr && (i_addr == wdf_pkg::ADDR_CTRL);
  assign wr_f1_key = i_wr && (i_addr == wdf_pkg::ADDR_FEED1) && (i_wdata == wdf_pkg::FEED1_KEY);
  // only the exact pair completes a feed
  assign feed_ok = (feed_r == wdf_pkg::FEED_ARMED) && i_wr && (i_addr == wdf_pkg::ADDR_FEED2)
                   && (i_wdata == wdf_pkg::FEED2_KEY);
  // anything else after the first key breaks the sequence
  assign bad_feed = (feed_r == wdf_pkg::FEED_ARMED) && acc && !feed_ok;

  // tap mask holds the low 5+sel bits; all ones there means the tap rolls
  assign tap_mask = wdf_pkg::PRE_ONES >> (4'd8 - {1'b0, sel_r});
  assign tick = run_r && timer_source_clock_en && ((pre_r & tap_mask) == tap_mask);
  // limitation: an underflow in the very cycle of a good feed still resets
  assign uf = tick && (cnt_r == 8'h00);
  // a stopped watchdog never resets, even on a broken feed
  assign wdg_rst = uf || (bad_feed && run_r);

  // core next state
  always_comb begin
    pre_nxt = pre_r;
    cnt_nxt = cnt_r;
    wdl_nxt = wdl_r;
    sel_nxt = sel_r;
    run_nxt = run_r;
    pend_sel_nxt = pend_sel_r;
    pend_run_nxt = pend_run_r;
    tof_nxt = tof_r;
    feed_nxt = feed_r;
    rst_nxt = wdg_rst;
    // prescaler and counter; software has no direct path to cnt_r
    if (feed_ok || wdg_rst) begin
      pre_nxt = 13'h0000;
      cnt_nxt = wdl_r;
    end else if (run_r && timer_source_clock_en) begin
      pre_nxt = pre_r + 13'h0001;
      if (tick) begin
        cnt_nxt = cnt_r - 8'h01;
      end
    end
    // autoload takes any byte, zero included
    if (i_wr && (i_addr == wdf_pkg::ADDR_AUTOLOAD)) begin
      wdl_nxt = i_wdata;
    end
    // control writes to select and run only land in the pending copy
    if (wr_ctrl) begin
      pend_sel_nxt = i_wdata[wdf_pkg::CTRL_SEL_HI:wdf_pkg::CTRL_SEL_LO];
      pend_run_nxt = i_wdata[wdf_pkg::CTRL_RUN];
    end
    // commit on a valid feed; this is how software stops the watchdog
    if (feed_ok) begin
      sel_nxt = pend_sel_r;
      run_nxt = pend_run_r;
    end
    // flag: software may clear it, a new timeout wins over the clear
    if (wr_ctrl && !i_wdata[wdf_pkg::CTRL_TOF]) begin
      tof_nxt = 1'b0;
    end
    if (wdg_rst) begin
      tof_nxt = 1'b1;
    end
    // feed sequence: first key arms exactly one following access
    case (feed_r)
      wdf_pkg::FEED_IDLE: begin
        if (wr_f1_key) begin
          feed_nxt = wdf_pkg::FEED_ARMED;
        end
      end
      wdf_pkg::FEED_ARMED: begin
        if (acc) begin
          feed_nxt = wdf_pkg::FEED_IDLE;
        end
      end
      default: begin
        feed_nxt = wdf_pkg::FEED_IDLE;
      end
    endcase
  end

  // core registers; external reset restarts a running watchdog
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      pre_r <= 13'h0000;
      cnt_r <= wdf_pkg::AUTOLOAD_RST; // autoload of the cleared value
      wdl_r <= wdf_pkg::AUTOLOAD_RST;
      sel_r <= wdf_pkg::SEL_RST;
      run_r <= wdf_pkg::RUN_RST;
      pend_sel_r <= wdf_pkg::SEL_RST;
      pend_run_r <= wdf_pkg::RUN_RST;
      tof_r <= 1'b0;
      feed_r <= wdf_pkg::FEED_IDLE;
      rst_r <= 1'b0;
    end else begin
      pre_r <= pre_nxt;
      cnt_r <= cnt_nxt;
      wdl_r <= wdl_nxt;
      sel_r <= sel_nxt;
      run_r <= run_nxt;
      pend_sel_r <= pend_sel_nxt;
      pend_run_r <= pend_run_nxt;
      tof_r <= tof_nxt;
      feed_r <= feed_nxt;
      rst_r <= rst_nxt;
    end
  end

  // read mux; control shows committed values, not pending ones
  always_comb begin
    rdata_nxt = 8'h00;
    if (i_rd) begin
      if (i_addr == wdf_pkg::ADDR_CTRL) begin
        rdata_nxt[wdf_pkg::CTRL_SEL_HI:wdf_pkg::CTRL_SEL_LO] = sel_r;
        rdata_nxt[wdf_pkg::CTRL_RUN] = run_r;
        rdata_nxt[wdf_pkg::CTRL_TOF] = tof_r;
      end else if (i_addr == wdf_pkg::ADDR_AUTOLOAD) begin
        rdata_nxt = wdl_r;
      end else if (i_addr == wdf_pkg::ADDR_COUNT) begin
        rdata_nxt = cnt_r;
      end else begin
        rdata_nxt = 8'h00; // feed registers and holes read zero
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign o_rdata = rdata_r;
  assign o_wdt_reset = rst_r;
  assign o_timeout = tof_r;

  // sequences used by the checks below
  sequence s_armed_then_wrong;
    (feed_r == wdf_pkg::FEED_ARMED) && acc && !feed_ok && run_r;
  endsequence
  sequence s_good_pair;
    wr_f1_key && (feed_r == wdf_pkg::FEED_IDLE) ##1 feed_ok;
  endsequence
  sequence s_wrong_second_key;
    (feed_r == wdf_pkg::FEED_ARMED) && i_wr && (i_addr == wdf_pkg::ADDR_FEED2)
      && (i_wdata != wdf_pkg::FEED2_KEY) && run_r;
  endsequence

  a_reset_values: assert property (@(posedge i_clk_sys)
    i_srst |=> run_r && (sel_r == 3'h7) && (wdl_r == 8'h00) && !tof_r && (pre_r == 13'h0000))
    else $error("reset values wrong");
  a_underflow_reset: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    uf |=> o_wdt_reset && (cnt_r == $past(wdl_r)) && (pre_r == 13'h0000))
    else $error("underflow without reset and reload");
  a_feed_reload: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    s_good_pair |=> (cnt_r == $past(wdl_r)) && (pre_r == 13'h0000) && !o_wdt_reset)
    else $error("feed pair did not reload");
  a_bad_feed: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    s_armed_then_wrong |=> o_wdt_reset && tof_r)
    else $error("broken feed did not reset");
  a_ctrl_pending: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    wr_ctrl && !feed_ok |=> (sel_r == $past(sel_r)) && (run_r == $past(run_r)))
    else $error("control applied without feed");
  a_stopped_hold: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    !run_r && !feed_ok |=> $stable(cnt_r) && $stable(pre_r) && !o_wdt_reset)
    else $error("stopped watchdog moved");
  a_fast_tap: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    run_r && (sel_r == 3'h0) && timer_source_clock_en && (pre_r[4:0] == 5'h1F) |-> tick)
    else $error("fastest tap missed");
  a_arm_once: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (feed_r == wdf_pkg::FEED_ARMED) && acc |=> (feed_r == wdf_pkg::FEED_IDLE))
    else $error("arm outlived one access");
  a_flag_keep: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    uf |=> tof_r && (wdl_r == $past(wdl_r)) && (sel_r == $past(sel_r)) && run_r)
    else $error("underflow disturbed settings");
  // read data stands one cycle only, then falls back to zero
  a_rdata_idle: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    !i_rd |=> (o_rdata == 8'h00))
    else $error("read data outlived its cycle");
  // a software clear lands at once unless a new timeout collides with it
  a_flag_clear: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    wr_ctrl && !i_wdata[wdf_pkg::CTRL_TOF] && !wdg_rst |=> !o_timeout)
    else $error("flag clear ignored");
  // set wins: a timeout in the clearing cycle still leaves the flag up
  a_flag_set_wins: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    wdg_rst |=> o_timeout)
    else $error("timeout flag not set");
  // one decrement per tick, judged on the count itself, not the tick term
  a_counter_step: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    tick && (cnt_r != 8'h00) && !feed_ok && !wdg_rst |=> (cnt_r == $past(cnt_r) - 8'h01))
    else $error("counter missed a tick");
  // commit copies the pending pair into the live control
  a_feed_commit: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    feed_ok |=> (sel_r == $past(pend_sel_r)) && (run_r == $past(pend_run_r)))
    else $error("feed did not commit control");
  // a write aimed at the counter index must not move it
  a_no_direct_load: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    i_wr && (i_addr == wdf_pkg::ADDR_COUNT) && !tick && !feed_ok && !wdg_rst |=> $stable(cnt_r))
    else $error("counter written directly");
  // prescaler only moves on a timer enable, or clears on an autoload
  a_pre_hold: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    !timer_source_clock_en && !feed_ok && !wdg_rst |=> $stable(pre_r))
    else $error("prescaler moved off its enable");
  // wrong second key: reset in the very next cycle, counter autoloaded
  a_wrong_key: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    s_wrong_second_key |=> o_wdt_reset && (cnt_r == $past(wdl_r)))
    else $error("wrong second key did not reset");

endmodule : wdf_watchdog
`default_nettype wire

/* tb/watchdog_with_feed_sequence_bench.sv */
// self-checking bench for the watchdog with feed sequence
`timescale 1ns/1ns
`default_nettype none
`define CHK(what, exp, got) begin comparisons++; if ((got) !== (exp)) begin fail_count++; \
  $display("Error %s expected %h seen %h", what, exp, got); end end
module watchdog_with_feed_sequence_bench;
  localparam int DIV_N = 4; // fastest legal divider keeps spans short
  logic i_clk_sys; // system clock
  logic i_srst; // synchronous reset
  logic [3:0] i_addr; // register index
  logic [7:0] i_wdata; // write data
  logic i_wr; // write strobe
  logic i_rd; // read strobe
  logic [7:0] o_rdata; // read data
  logic o_wdt_reset; // reset request pulse
  logic o_timeout; // timeout flag
  int fail_count; // mismatches
  int comparisons; // checks made
  int n; // cycles waited
  wdf_watchdog #(.DIV_N(DIV_N)) i_dut (.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_wdt_reset(o_wdt_reset), .o_timeout(o_timeout));
  // free-running clock
  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  // one bus cycle; strobes stay as set until the next call
  task automatic acc(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d);
    i_wr <= w;
    i_rd <= r;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
  endtask : acc
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    acc(1'b1, 1'b0, a, d);
    acc(1'b0, 1'b0, 4'h0, 8'h00);
  endtask : wr
  // read data is looked at only in the cycle after the strobe
  task automatic rd_chk(input string what, input logic [3:0] a, input logic [7:0] exp);
    acc(1'b0, 1'b1, a, 8'h00);
    #1;
    `CHK(what, exp, o_rdata)
    acc(1'b0, 1'b0, 4'h0, 8'h00);
  endtask : rd_chk
  task automatic feed();
    acc(1'b1, 1'b0, wdf_pkg::ADDR_FEED1, wdf_pkg::FEED1_KEY);
    acc(1'b1, 1'b0, wdf_pkg::ADDR_FEED2, wdf_pkg::FEED2_KEY);
    acc(1'b0, 1'b0, 4'h0, 8'h00);
  endtask : feed
  // bounded wait for the reset pulse, counting edges
  task automatic wait_reset(input int lim, output int cnt);
    cnt = 0;
    while (cnt < lim) begin
      @(posedge i_clk_sys);
      #1;
      cnt++;
      if (o_wdt_reset === 1'b1) break;
    end
  endtask : wait_reset
  task automatic t_reset();
    `CHK("timeout out", 1'b0, o_timeout)
    rd_chk("ctrl", wdf_pkg::ADDR_CTRL, 8'hE4);
    rd_chk("autoload", wdf_pkg::ADDR_AUTOLOAD, 8'h00);
    rd_chk("counter", wdf_pkg::ADDR_COUNT, 8'h00);
    rd_chk("unmapped", 4'hF, 8'h00);
    // nobody fed: top tap, zero autoload must fire on its own
    wait_reset(4096 * DIV_N + 40, n);
    `CHK("reset span", 1'b1, (n >= 4096 * DIV_N - 30 && n <= 4096 * DIV_N + 4))
    $display("test reset done");
  endtask : t_reset
  task automatic t_pending();
    wr(wdf_pkg::ADDR_CTRL, 8'h04);
    rd_chk("ctrl pending", wdf_pkg::ADDR_CTRL, 8'hE4);
    wr(wdf_pkg::ADDR_AUTOLOAD, 8'hFF);
    rd_chk("autoload ff", wdf_pkg::ADDR_AUTOLOAD, 8'hFF);
    wr(wdf_pkg::ADDR_AUTOLOAD, 8'h03);
    feed();
    rd_chk("ctrl committed", wdf_pkg::ADDR_CTRL, 8'h04);
    rd_chk("counter fed", wdf_pkg::ADDR_COUNT, 8'h03);
    wr(wdf_pkg::ADDR_COUNT, 8'h10);
    rd_chk("counter kept", wdf_pkg::ADDR_COUNT, 8'h03);
    // span is now 512 clocks; feeds every ~403 clocks must keep it quiet
    for (int k = 0; k < 3; k++) begin
      wait_reset(400, n);
      `CHK("fed in time", 400, n)
      feed();
    end
    $display("test pending done");
  endtask : t_pending
  // every select code, zero autoload: span is DIV_N times divisor
  task automatic t_span();
    int exp;
    for (int s = 0; s < 8; s++) begin
      exp = DIV_N * (32 << s);
      wr(wdf_pkg::ADDR_CTRL, {s[2:0], 5'h04});
      wr(wdf_pkg::ADDR_AUTOLOAD, 8'h00);
      `CHK("flag cleared", 1'b0, o_timeout)
      feed();
      wait_reset(exp + 40, n);
      // counted from the edge after the good pair; enable phase costs up to DIV_N-1
      `CHK("span", 1'b1, (n >= exp - DIV_N && n <= exp - 1))
      `CHK("flag set", 1'b1, o_timeout)
      rd_chk("ctrl after", wdf_pkg::ADDR_CTRL, {s[2:0], 5'h06});
    end
    $display("test span done");
  endtask : t_span
  // broken feeds: wrong key, a read between, a second first key
  task automatic t_badfeed();
    wr(wdf_pkg::ADDR_CTRL, 8'h04);
    wr(wdf_pkg::ADDR_AUTOLOAD, 8'hFF);
    feed();
    for (int k = 0; k < 3; k++) begin
      acc(1'b1, 1'b0, wdf_pkg::ADDR_FEED1, wdf_pkg::FEED1_KEY);
      if (k == 0) acc(1'b1, 1'b0, wdf_pkg::ADDR_FEED2, 8'h00);
      else if (k == 1) acc(1'b0, 1'b1, wdf_pkg::ADDR_CTRL, 8'h00);
      else acc(1'b1, 1'b0, wdf_pkg::ADDR_FEED1, wdf_pkg::FEED1_KEY);
      #1;
      `CHK("broken feed reset", 1'b1, o_wdt_reset)
      `CHK("broken feed flag", 1'b1, o_timeout)
      acc(1'b0, 1'b0, 4'h0, 8'h00);
      #1;
      `CHK("reset pulse ends", 1'b0, o_wdt_reset)
      wr(wdf_pkg::ADDR_CTRL, 8'h04);
    end
    rd_chk("counter autoloaded", wdf_pkg::ADDR_COUNT, 8'hFF);
    $display("test badfeed done");
  endtask : t_badfeed
  task automatic t_disable();
    wr(wdf_pkg::ADDR_AUTOLOAD, 8'h00);
    wr(wdf_pkg::ADDR_CTRL, 8'h00);
    feed();
    rd_chk("ctrl off", wdf_pkg::ADDR_CTRL, 8'h00);
    acc(1'b1, 1'b0, wdf_pkg::ADDR_FEED1, wdf_pkg::FEED1_KEY);
    acc(1'b1, 1'b0, wdf_pkg::ADDR_FEED2, 8'h00);
    #1;
    `CHK("stopped no reset", 1'b0, o_wdt_reset)
    acc(1'b0, 1'b0, 4'h0, 8'h00);
    wait_reset(600, n);
    `CHK("stopped quiet", 600, n)
    $display("test disable done");
  endtask : t_disable
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test
  // hang guard, well past the longest expected run
  initial begin
    #1_000_000;
    fail_count++;
    end_of_test();
  end
  // main sequence
  initial begin
    fail_count = 0;
    comparisons = 0;
    i_srst = 1'b1;
    i_addr = 4'h0;
    i_wdata = 8'h00;
    i_wr = 1'b0;
    i_rd = 1'b0;
    repeat (6) @(posedge i_clk_sys);
    i_srst <= 1'b0;
    t_reset();
    t_pending();
    t_span();
    t_badfeed();
    t_disable();
    end_of_test();
  end
endmodule : watchdog_with_feed_sequence_bench
`default_nettype wire
